// ===== design/quad_dac_consts.svh
// constants of the quad converter serial update control
`ifndef QUAD_DAC_CONSTS_SVH
`define QUAD_DAC_CONSTS_SVH

// frame length in serial-clock falling edges
`define QD_FRAME_BITS 24
// number of converter channels
`define QD_CHANNELS 4
// width of the frame status counters
`define QD_STAT_W 8

// reset values
`define QD_CODE_RESET 16'h0000
`define QD_REF_RESET 1'b1
`define QD_AMP_RESET 1'b1
`define QD_STAT_RESET 8'h00

// frame field positions, most significant bit sent first
`define QD_POS_ADDR_HIGH 23
`define QD_POS_ADDR_LOW 22
`define QD_POS_LOAD_HIGH 21
`define QD_POS_LOAD_LOW 20
`define QD_POS_ZERO 19
`define QD_POS_SEL_HIGH 18
`define QD_POS_SEL_LOW 17
`define QD_POS_PD_PRIMARY 16
`define QD_POS_PD_MODE_A 15
`define QD_POS_PD_MODE_B 14

// power-down patterns on primary, mode a, mode b
`define QD_PD_REF_CMD 3'h4
`define QD_PD_1K 3'h5
`define QD_PD_100K 3'h6
`define QD_PD_HIZ 3'h7

// reference-change codes carried on data bits 13 and 12
`define QD_REF_ON 2'h1
`define QD_REF_OFF 2'h2

`endif

// ===== design/quad_dac_pkg.sv
// types shared by the quad converter serial update control
package quad_dac_pkg;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_1K = 4'h2,
    MODE_100K = 4'h4,
    MODE_HIZ = 4'h8
  } out_mode_t;

  typedef enum logic [1:0] {
    LOAD_STORE = 2'h0,
    LOAD_SINGLE = 2'h1,
    LOAD_ALL = 2'h2,
    LOAD_BCAST = 2'h3
  } load_cmd_t;

  typedef struct packed {
    logic [15:0] code;
    out_mode_t mode;
  } channel_t;

  typedef struct packed {
    logic addr_strap_high;
    logic addr_strap_low;
    load_cmd_t load_cmd;
    logic reserved_zero;
    logic [1:0] chan_sel;
    logic powerdown_primary_bit;
    logic powerdown_mode_bit_a;
    logic powerdown_mode_bit_b;
    logic [13:0] data_low;
  } frame_t;

endpackage

// ===== design/serial_frame_rx.sv
// serial-clock side: frame shift register, bit counter and completed-frame hold
`include "quad_dac_consts.svh"

module serial_frame_rx #(
  parameter int FRAME_BITS = `QD_FRAME_BITS
) (
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_din,
  input wire logic port_disable,
  output logic [FRAME_BITS-1:0] frame_word,
  output logic frame_toggle
);

  localparam int CW = $clog2(FRAME_BITS + 1);

  typedef struct packed {
    logic [FRAME_BITS-2:0] shift;
    logic [CW-1:0] count;
  } shift_state_t;

  typedef struct packed {
    logic [FRAME_BITS-1:0] word;
    logic toggle;
  } hold_state_t;

  shift_state_t s, next_s;
  hold_state_t h, next_h;
  logic clear;

  // ****************************************************
  // frame clear: sync high, port disabled or reset
  // ****************************************************
  // the serial clock stops between frames, so the frame's own level clears
  assign clear = rst | frame_sync_n | port_disable;

  always_comb begin
    next_s = s;
    next_h = h;
    if (s.count < CW'(FRAME_BITS)) begin
      next_s.shift = {s.shift[FRAME_BITS-3:0], serial_din};
      next_s.count = CW'(s.count + 1'b1);
      if (s.count == CW'(FRAME_BITS - 1)) begin
        next_h.word = {s.shift, serial_din};
        next_h.toggle = ~h.toggle;
      end
    end
  end

  always_ff @(negedge sclk or posedge clear) begin
    if (clear) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // completed frame outlives the sync rise so the system side can take it
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  assign frame_word = h.word;
  assign frame_toggle = h.toggle;

endmodule

// ===== design/quad_dac_serial_update_control.sv
// quad converter digital control: frame decode, buffers, converter registers
// What this block does
// - frame sync low for 24 falling edges; register updates on the 24th
// - sync rising before the 24th edge discards the frame, nothing changes
// - converter registers clear to zero at power-up
// - reference starts enabled, changes only on a valid reference command
// - load strobe rising edge copies every buffer into its converter register
// - channels with unchanged buffers keep their output on a strobe
// - port-disable pin high makes the block ignore the serial port
// - channel mode taken from frame bits 16, 15 and 14
// - primary bit 0 normal; 101 1k, 110 100k, 111 high impedance
// - power-down settings follow every store, load and all command, and broadcasts with bit 18 set
// - powered-down channel disconnects amplifier, selects resistor or open
// - entering power-down leaves the stored converter code untouched
// - store-and-load-all writes the buffer then loads all four registers
// - single update writes the buffer and loads that channel's register
// - frame is 24 bits: eight control bits then a 16-bit word
// - address mismatch ignores the frame unless it is a broadcast
// - load bits: 00 store, 01 single, 10 all, 11 broadcast
// - select bits pick A to D; broadcast bit 18 picks reload or frame data
`include "quad_dac_consts.svh"

module quad_dac_serial_update_control #(
  parameter int FRAME_BITS = `QD_FRAME_BITS,
  parameter int CHANNELS = `QD_CHANNELS,
  parameter int STAT_W = `QD_STAT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_din,
  input wire logic port_disable,
  input wire logic async_load_strobe,
  input wire logic addr_strap_high,
  input wire logic addr_strap_low,
  output quad_dac_pkg::channel_t [CHANNELS-1:0] dac_reg,
  output quad_dac_pkg::channel_t [CHANNELS-1:0] data_buffer,
  output logic [CHANNELS-1:0] amp_enable,
  output logic ref_enable,
  output logic [STAT_W-1:0] frames_accepted,
  output logic [STAT_W-1:0] frames_ignored
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [2:0] frame_sync_pipe;
    logic [2:0] strobe_sync;
    logic [1:0] strap_high_sync;
    logic [1:0] strap_low_sync;
    quad_dac_pkg::channel_t [CHANNELS-1:0] buffer;
    quad_dac_pkg::channel_t [CHANNELS-1:0] dac;
    logic [CHANNELS-1:0] amp_enable;
    logic ref_enable;
    logic [STAT_W-1:0] accepted;
    logic [STAT_W-1:0] ignored;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  logic [FRAME_BITS-1:0] frame_word;
  logic frame_toggle;

  quad_dac_pkg::frame_t fr;
  quad_dac_pkg::channel_t entry;
  logic frame_event;
  logic strobe_rise;
  logic addressed;
  logic is_bcast;
  logic frame_valid;
  logic [2:0] pd_pattern;
  logic ref_cmd;
  logic [15:0] frame_data;

  // ****************************************************
  // serial-clock side
  // ****************************************************
  serial_frame_rx #(
    .FRAME_BITS(FRAME_BITS)
  ) u_rx (
    .rst(rst),
    .sclk(sclk),
    .frame_sync_n(frame_sync_n),
    .serial_din(serial_din),
    .port_disable(port_disable),
    .frame_word(frame_word),
    .frame_toggle(frame_toggle)
  );

  // ****************************************************
  // channel entry built from a frame
  // ****************************************************
  // power-down changes only the mode; the held code survives it
  function automatic quad_dac_pkg::channel_t make_entry(
    input quad_dac_pkg::channel_t old,
    input logic [2:0] pattern,
    input logic [15:0] word
  );
    quad_dac_pkg::channel_t e;
    e = old;
    if (!pattern[2]) begin
      e.code = word;
      e.mode = quad_dac_pkg::MODE_NORMAL;
    end else begin
      case (pattern)
        `QD_PD_1K: begin
          e.mode = quad_dac_pkg::MODE_1K;
        end
        `QD_PD_100K: begin
          e.mode = quad_dac_pkg::MODE_100K;
        end
        `QD_PD_HIZ: begin
          e.mode = quad_dac_pkg::MODE_HIZ;
        end
        default: begin
          e.mode = old.mode;
        end
      endcase
    end
    return e;
  endfunction

  // ****************************************************
  // frame decode
  // ****************************************************
  always_comb begin
    fr = quad_dac_pkg::frame_t'(frame_word);
    frame_data = {fr.powerdown_mode_bit_a, fr.powerdown_mode_bit_b, fr.data_low};
    pd_pattern = {fr.powerdown_primary_bit, fr.powerdown_mode_bit_a,
                  fr.powerdown_mode_bit_b};
    ref_cmd = (pd_pattern == `QD_PD_REF_CMD);
    // toggle edge means a complete frame sits stable in the hold register
    frame_event = s.frame_sync_pipe[2] ^ s.frame_sync_pipe[1];
    strobe_rise = s.strobe_sync[1] & ~s.strobe_sync[2];
    // straps must match bits 23 and 22, as the host promises
    addressed = (fr.addr_strap_high == s.strap_high_sync[1]) &&
                (fr.addr_strap_low == s.strap_low_sync[1]);
    is_bcast = (fr.load_cmd == quad_dac_pkg::LOAD_BCAST);
    // bit 19 set is not a legal frame and is dropped
    frame_valid = frame_event & ~fr.reserved_zero & (addressed | is_bcast);
    entry = make_entry(s.buffer[fr.chan_sel], pd_pattern, frame_data);
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_s = s;

    // two-stage synchronisers, third stage only for edge detection
    next_s.frame_sync_pipe = {s.frame_sync_pipe[1:0], frame_toggle};
    next_s.strobe_sync = {s.strobe_sync[1:0], async_load_strobe};
    next_s.strap_high_sync = {s.strap_high_sync[0], addr_strap_high};
    next_s.strap_low_sync = {s.strap_low_sync[0], addr_strap_low};

    if (frame_valid && ref_cmd) begin
      // reference command touches neither buffers nor registers
      case (fr.data_low[13:12])
        `QD_REF_ON: begin
          next_s.ref_enable = 1'b1;
        end
        `QD_REF_OFF: begin
          next_s.ref_enable = 1'b0;
        end
        default: begin
          next_s.ref_enable = s.ref_enable;
        end
      endcase
    end else if (frame_valid) begin
      case (fr.load_cmd)
        quad_dac_pkg::LOAD_STORE: begin
          // buffer only: prepares a later strobe or simultaneous load
          next_s.buffer[fr.chan_sel] = entry;
        end
        quad_dac_pkg::LOAD_SINGLE: begin
          next_s.buffer[fr.chan_sel] = entry;
          next_s.dac[fr.chan_sel] = entry;
        end
        quad_dac_pkg::LOAD_ALL: begin
          next_s.buffer[fr.chan_sel] = entry;
          for (int i = 0; i < CHANNELS; i++) begin
            next_s.dac[i] = next_s.buffer[i];
          end
        end
        quad_dac_pkg::LOAD_BCAST: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (fr.chan_sel[1]) begin
              // frame data or power-down goes to every channel
              next_s.buffer[i] = make_entry(s.buffer[i], pd_pattern, frame_data);
              next_s.dac[i] = next_s.buffer[i];
            end else begin
              // reload every channel from what its buffer holds
              next_s.dac[i] = s.buffer[i];
            end
          end
        end
        default: begin
          next_s.buffer = s.buffer;
        end
      endcase
    end

    // strobe copies after the frame's buffer write, so the newest entry wins;
    // an untouched buffer still equals its register and so nothing moves
    if (strobe_rise) begin
      for (int i = 0; i < CHANNELS; i++) begin
        next_s.dac[i] = next_s.buffer[i];
      end
    end

    // amplifier drives the pin only in normal mode
    for (int i = 0; i < CHANNELS; i++) begin
      next_s.amp_enable[i] = (next_s.dac[i].mode == quad_dac_pkg::MODE_NORMAL);
    end

    if (frame_valid) begin
      next_s.accepted = STAT_W'(s.accepted + 1'b1);
    end else if (frame_event) begin
      next_s.ignored = STAT_W'(s.ignored + 1'b1);
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s.frame_sync_pipe <= 3'h0;
      s.strobe_sync <= 3'h0;
      s.strap_high_sync <= 2'h0;
      s.strap_low_sync <= 2'h0;
      for (int i = 0; i < CHANNELS; i++) begin
        s.buffer[i].code <= `QD_CODE_RESET;
        s.buffer[i].mode <= quad_dac_pkg::MODE_NORMAL;
        s.dac[i].code <= `QD_CODE_RESET;
        s.dac[i].mode <= quad_dac_pkg::MODE_NORMAL;
      end
      s.amp_enable <= {CHANNELS{`QD_AMP_RESET}};
      s.ref_enable <= `QD_REF_RESET;
      s.accepted <= `QD_STAT_RESET;
      s.ignored <= `QD_STAT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign dac_reg = s.dac;
  assign data_buffer = s.buffer;
  assign amp_enable = s.amp_enable;
  assign ref_enable = s.ref_enable;
  assign frames_accepted = s.accepted;
  assign frames_ignored = s.ignored;

endmodule

// ===== tb/quad_dac_serial_update_control_props.sv
// assertion checker for the quad converter serial update control
module quad_dac_serial_update_control_props #(
  parameter int FRAME_BITS = 24,
  parameter int CHANNELS = 4,
  parameter int STAT_W = 8
) (
  input logic clk,
  input logic rst,
  input logic sclk,
  input logic frame_sync_n,
  input logic serial_din,
  input logic port_disable,
  input logic async_load_strobe,
  input logic addr_strap_high,
  input logic addr_strap_low,
  input quad_dac_pkg::channel_t [CHANNELS-1:0] dac_reg,
  input quad_dac_pkg::channel_t [CHANNELS-1:0] data_buffer,
  input logic [CHANNELS-1:0] amp_enable,
  input logic ref_enable,
  input logic [STAT_W-1:0] frames_accepted,
  input logic [STAT_W-1:0] frames_ignored
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [CHANNELS-1:0] normal_mode;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) normal_mode[i] = dac_reg[i].mode == quad_dac_pkg::MODE_NORMAL;
  end
  reset_state_a: assert property ($fell(rst) |-> ref_enable && data_buffer == dac_reg)
    else $error("state after reset wrong");
  amp_mode_a: assert property (amp_enable == normal_mode)
    else $error("amplifier enable disagrees with mode");
  buffer_cause_a: assert property ($changed(data_buffer) |-> $changed(frames_accepted))
    else $error("buffer changed without accepted frame");
  ref_cause_a: assert property ($changed(ref_enable) |-> $changed(frames_accepted))
    else $error("reference changed without accepted frame");
  count_step_a: assert property ($changed(frames_accepted) |->
    frames_accepted == STAT_W'($past(frames_accepted) + 1'b1))
    else $error("accepted count did not step by one");
  ignore_quiet_a: assert property ($changed(frames_ignored) |-> $stable(data_buffer)
    && $stable(ref_enable) && $stable(frames_accepted))
    else $error("ignored frame had an effect");
  disable_quiet_a: assert property (port_disable [*8] |-> $stable(frames_accepted)
    && $stable(frames_ignored))
    else $error("frame seen while port disabled");
  strobe_copy_a: assert property ($rose(async_load_strobe) |-> ##[1:4] dac_reg == data_buffer)
    else $error("strobe did not copy buffers");
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    pd_code_a: assert property ($changed(data_buffer[i].mode)
      && data_buffer[i].mode != quad_dac_pkg::MODE_NORMAL |-> $stable(data_buffer[i].code))
      else $error("code moved on power-down");
  end
endmodule

bind quad_dac_serial_update_control quad_dac_serial_update_control_props #(
  .FRAME_BITS(FRAME_BITS), .CHANNELS(CHANNELS), .STAT_W(STAT_W)) u_props (
  .clk(clk), .rst(rst), .sclk(sclk), .frame_sync_n(frame_sync_n), .serial_din(serial_din),
  .port_disable(port_disable), .async_load_strobe(async_load_strobe),
  .addr_strap_high(addr_strap_high), .addr_strap_low(addr_strap_low), .dac_reg(dac_reg),
  .data_buffer(data_buffer), .amp_enable(amp_enable), .ref_enable(ref_enable),
  .frames_accepted(frames_accepted), .frames_ignored(frames_ignored));

// ===== tb/serial_host.sv
// behavioural serial host sending write frames
module serial_host (
  output logic sclk,
  output logic frame_sync_n,
  output logic serial_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    serial_din = 1'b0;
  end
  // clock stands high between frames; released data shows the inverse of its last bit
  task automatic send(input logic [23:0] f, input int n);
    #3 frame_sync_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      serial_din = f[i];
      #6 sclk = 1'b0;
      #6 sclk = 1'b1;
    end
    #6 frame_sync_n = 1'b1;
    serial_din = ~serial_din;
  endtask
endmodule

// ===== tb/quad_dac_serial_update_control_bench.sv
// self-checking bench for the quad converter serial update control
module quad_dac_serial_update_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic port_disable = 1'b0;
  logic async_load_strobe = 1'b0;
  logic addr_strap_high = 1'b1;
  logic addr_strap_low = 1'b0;
  wire sclk, frame_sync_n, serial_din;
  quad_dac_pkg::channel_t [3:0] dac_reg, data_buffer, ebuf, edac;
  logic [3:0] amp_enable;
  logic ref_enable, eref;
  logic [7:0] frames_accepted, frames_ignored, eacc, eign;
  logic [180:0] seen, last, q[$];
  int miscompares, compares, seed;
  assign seen = {dac_reg, data_buffer, amp_enable, ref_enable, frames_accepted, frames_ignored};
  initial forever #25 clk = ~clk;
  serial_host u_host (.sclk(sclk), .frame_sync_n(frame_sync_n), .serial_din(serial_din));
  quad_dac_serial_update_control u_quad_dac_serial_update_control (.clk(clk), .rst(rst),
    .sclk(sclk), .frame_sync_n(frame_sync_n), .serial_din(serial_din),
    .port_disable(port_disable), .async_load_strobe(async_load_strobe),
    .addr_strap_high(addr_strap_high), .addr_strap_low(addr_strap_low), .dac_reg(dac_reg),
    .data_buffer(data_buffer), .amp_enable(amp_enable), .ref_enable(ref_enable),
    .frames_accepted(frames_accepted), .frames_ignored(frames_ignored));
  function automatic logic [180:0] snap();
    logic [3:0] amp;
    for (int i = 0; i < 4; i++) amp[i] = edac[i].mode == quad_dac_pkg::MODE_NORMAL;
    return {edac, ebuf, amp, eref, eacc, eign};
  endfunction
  function automatic quad_dac_pkg::channel_t entry(quad_dac_pkg::channel_t old, logic [23:0] f);
    entry = old;
    case (f[16:14])
      3'h5: entry.mode = quad_dac_pkg::MODE_1K;
      3'h6: entry.mode = quad_dac_pkg::MODE_100K;
      3'h7: entry.mode = quad_dac_pkg::MODE_HIZ;
      default: entry = {f[15:0], quad_dac_pkg::MODE_NORMAL};
    endcase
  endfunction
  task automatic chk(input logic [180:0] got, input logic [180:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // work out the expected state, note it, then send the frame
  task automatic frame(input logic [23:0] f, input int n = 24);
    if (n == 24 && !port_disable) begin
      if (f[19] || (f[21:20] != 2'h3 && f[23:22] != {addr_strap_high, addr_strap_low})) eign++;
      else begin
        eacc++;
        if (f[16:14] == 3'h4) begin
          if (f[13:12] == 2'h1) eref = 1'b1;
          else if (f[13:12] == 2'h2) eref = 1'b0;
        end else if (f[21:20] == 2'h3) begin
          for (int i = 0; i < 4; i++) begin
            if (f[18]) ebuf[i] = entry(ebuf[i], f);
            edac[i] = ebuf[i];
          end
        end else begin
          ebuf[f[18:17]] = entry(ebuf[f[18:17]], f);
          if (f[21:20] == 2'h1) edac[f[18:17]] = ebuf[f[18:17]];
          if (f[21:20] == 2'h2) edac = ebuf;
        end
      end
      q.push_back(snap());
    end
    u_host.send(f, n);
    repeat (10) @(posedge clk);
  endtask
  task automatic strobe();
    logic [180:0] old;
    old = snap();
    edac = ebuf;
    if (snap() !== old) q.push_back(snap());
    @(posedge clk) async_load_strobe <= 1'b1;
    repeat (8) @(posedge clk);
    async_load_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk) begin
    if (!rst && seen !== last) begin
      if (q.size() == 0) chk(seen, last);
      else chk(seen, q.pop_front());
      last = seen;
    end
  end
  initial begin
    #300us;
    miscompares++;
    summarize();
  end
  initial begin
    seed = 32'hd6728be8;
    for (int i = 0; i < 4; i++) ebuf[i] = {16'h0000, quad_dac_pkg::MODE_NORMAL};
    edac = ebuf;
    eref = 1'b1;
    eacc = 8'h00;
    eign = 8'h00;
    last = snap();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(seen, snap());
    for (int i = 0; i < 4; i++) frame({2'h2, 2'h0, 1'b0, 2'(i), 1'b0, 16'($random(seed))});
    strobe();
    frame({2'h2, 2'h0, 1'b0, 2'h1, 1'b0, 16'($random(seed))});
    strobe();
    frame({2'h2, 2'h1, 1'b0, 2'h2, 1'b0, 16'($random(seed))});
    frame({2'h2, 2'h0, 1'b0, 2'h0, 1'b0, 16'($random(seed))});
    frame({2'h2, 2'h2, 1'b0, 2'h3, 1'b0, 16'($random(seed))});
    frame({2'h1, 2'h1, 1'b0, 2'h0, 1'b0, 16'($random(seed))});
    frame({2'h2, 2'h1, 1'b1, 2'h0, 1'b0, 16'($random(seed))});
    frame({2'h1, 2'h3, 1'b0, 2'h2, 1'b0, 16'($random(seed))});
    frame({2'h2, 2'h0, 1'b0, 2'h1, 1'b0, 16'($random(seed))});
    frame({2'h0, 2'h3, 1'b0, 2'h0, 1'b0, 16'($random(seed))});
    for (int p = 5; p < 8; p++) frame({2'h2, 2'h1, 1'b0, 2'(p - 5), 1'b1, 2'(p), 14'h0000});
    frame({2'h0, 2'h3, 1'b0, 2'h2, 1'b1, 2'h3, 14'h0000});
    frame({2'h2, 2'h0, 1'b0, 2'h3, 1'b1, 2'h2, 14'h0000});
    strobe();
    frame({2'h2, 2'h0, 1'b0, 2'h0, 1'b1, 2'h0, 2'h3, 12'h000});
    frame({2'h2, 2'h0, 1'b0, 2'h0, 1'b1, 2'h0, 2'h2, 12'h000});
    frame({2'h2, 2'h0, 1'b0, 2'h0, 1'b1, 2'h0, 2'h1, 12'h000});
    frame({2'h2, 2'h1, 1'b0, 2'h3, 1'b0, 16'($random(seed))}, 23);
    port_disable <= 1'b1;
    repeat (8) @(posedge clk);
    frame({2'h2, 2'h1, 1'b0, 2'h3, 1'b0, 16'($random(seed))});
    port_disable <= 1'b0;
    @(posedge clk);
    frame({2'h2, 2'h1, 1'b0, 2'h3, 1'b0, 16'($random(seed))});
    chk(181'(q.size()), 181'(0));
    summarize();
  end
endmodule
